// File: fwid_pkg.sv
/*
  Shared constants and types for the flash wake and identification command block.
  Assumes a 100 MHz core clock and a serial link clocked by the host.
*/
package fwid_pkg;

  // Core clock period and wake timing
  localparam int CORE_CLK_PERIOD_NS = 10;
  localparam int WAKE_DELAY_NS = 100;
  localparam int WAKE_CYCLES_RAW = WAKE_DELAY_NS / CORE_CLK_PERIOD_NS;
  localparam int WAKE_CYCLES = (WAKE_CYCLES_RAW < 1) ? 1 : WAKE_CYCLES_RAW;
  // Select needs two sync flops and one decode edge before the count loads
  localparam int SEL_LATENCY_CYCLES = 3;
  localparam logic [7:0] WAKE_COUNT = 8'(WAKE_CYCLES - SEL_LATENCY_CYCLES);

  // Opcodes
  localparam logic [7:0] OP_WAKE_AND_CODE = 8'hab;
  localparam logic [7:0] OP_MAKER_DEVICE = 8'h90;
  localparam logic [7:0] OP_THREE_BYTE_IDENT = 8'h9f;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;

  // Address that swaps the maker and device code order
  localparam logic [23:0] SWAP_ADDR = 24'h000001;

  // Bit counts along a command
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] ADDR_END_BITS = 6'h20;

  // Last bit position of each answer pattern before it wraps
  localparam logic [4:0] SHIFT_LEN_CODE = 5'd7;
  localparam logic [4:0] SHIFT_LEN_PAIR = 5'd15;
  localparam logic [4:0] SHIFT_LEN_IDENT = 5'd23;

  // Shipped contents
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] STATUS_SHIPPED = 8'h00;

  // Identity values: arbitrary
  localparam logic [7:0] MAKER_CODE_DEFAULT = 8'h5a;
  localparam logic [7:0] DEVICE_CODE_DEFAULT = 8'h10;
  localparam logic [7:0] MEM_TYPE_DEFAULT = 8'h40;
  localparam logic [7:0] CAPACITY_DEFAULT = 8'h11;

  // Command interpreter states
  typedef enum logic [2:0] {
    FWID_IDLE = 3'b000,
    FWID_OPCODE = 3'b001,
    FWID_ADDR = 3'b011,
    FWID_SHIFT = 3'b010,
    FWID_IGNORE = 3'b110
  } fwid_state_type;

  // Pins seen after synchronising
  typedef struct packed {
    logic select_low;
    logic sclk;
    logic serial_in;
  } fwid_pins_type;

endpackage : fwid_pkg

// File: fwid_sync.sv
/*
  Two-flop synchroniser for a group of link pins.
  Assumes the pins are asynchronous to core_clk.
*/
`timescale 1ns/10ps
module fwid_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pins in and synchronised copy out
  input wire fwid_pkg::fwid_pins_type pins_in,
  output fwid_pkg::fwid_pins_type pins_out
);
  import fwid_pkg::*;

  fwid_pins_type stage1;
  fwid_pins_type stage2;
  fwid_pins_type next_stage1;
  fwid_pins_type next_stage2;

  // First stage feeds only the second
  always_comb begin
    next_stage1 = pins_in;
    next_stage2 = stage1;
  end

  // Idle link: select high, clock low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '{select_low: 1'b1, sclk: 1'b0, serial_in: 1'b0};
      stage2 <= '{select_low: 1'b1, sclk: 1'b0, serial_in: 1'b0};
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign pins_out = stage2;

endmodule : fwid_sync

// File: fwid_top.sv
/*
  Command interpreter for the wake-up and identification commands of a small
  serial flash: wake and device code, maker and device code, three-byte ident.
  Assumes the host drives select and serial clock (mode 0) well below core_clk/4,
  and that write_in_progress comes from the program and erase engine.
*/
// Operation
// - Wake opcode plus select rise leaves sleep
// - Wake opcode plus three dummies gives code
// - Code bits out on falling edge, MSB first
// - Code byte repeats until select rises
// - Wake with code read waits wake delay
// - Wake opcode ignored while write in progress
// - Maker read: opcode, address zero, maker, device
// - Address one gives device code first
// - Ident read: maker, memory type, capacity
// - Ident bits out on each falling edge
// - Ident opcode not decoded during write cycle
// - Select rise ends ident read, back standby
// - Shipped status byte zero, array erased
// - Asleep, only the wake opcode is heard
// - Wake delays no longer than 0.1 us
// - Write in progress held high through cycle
`timescale 1ns/10ps
module fwid_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial link pins
  input wire logic select_low_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  // Device state
  input wire logic write_in_progress,
  input wire logic sleep_request,
  output logic deep_sleep,
  output logic standby_ready,
  output logic [7:0] status_byte,
  output logic [7:0] array_read_byte
);
  import fwid_pkg::*;

  // Reset chain and synchronised pins
  logic rst_sync1;
  logic rst_sync2;
  logic next_rst_sync1;
  logic next_rst_sync2;
  logic rst_core_n;
  fwid_pins_type pins_raw;
  fwid_pins_type pins;

  // Interpreter state and command capture
  fwid_state_type state;
  fwid_state_type next_state;
  logic [7:0] opcode;
  logic [7:0] next_opcode;
  logic [23:0] addr;
  logic [23:0] next_addr;
  logic [5:0] bit_cnt;
  logic [5:0] next_bit_cnt;
  // Output shift path
  logic [23:0] shreg;
  logic [23:0] next_shreg;
  logic [4:0] shift_len;
  logic [4:0] next_shift_len;
  logic [4:0] shift_pos;
  logic [4:0] next_shift_pos;
  logic [23:0] payload;
  logic [23:0] next_payload;
  logic out_bit;
  logic next_out_bit;
  logic out_en;
  logic next_out_en;
  logic sleeping;
  logic next_sleeping;
  // Wake delay countdown, loaded on the select rise that wakes
  logic [7:0] wake_cnt;
  logic [7:0] next_wake_cnt;
  logic sclk_prev;
  logic next_sclk_prev;

  // Strobes derived from the synchronised pins
  logic sclk_rise;
  logic sclk_fall;
  logic sel_active;
  logic [7:0] opcode_full;

  // Reset chain next values; entry is immediate, release walks two flops
  always_comb begin
    next_rst_sync1 = 1'b1;
    next_rst_sync2 = rst_sync1;
  end

  // Reset released through two flops so release never lands near an edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= next_rst_sync1;
      rst_sync2 <= next_rst_sync2;
    end
  end
  assign rst_core_n = rst_sync2;

  // Link pins cross into the core domain
  assign pins_raw = '{select_low: select_low_pin, sclk: serial_clock_pin,
                      serial_in: serial_in_pin};

  fwid_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_core_n),
    .pins_in(pins_raw),
    .pins_out(pins)
  );

  // Edge finders on the synchronised copies only
  assign sclk_rise = pins.sclk & ~sclk_prev;
  assign sclk_fall = ~pins.sclk & sclk_prev;
  assign sel_active = ~pins.select_low;
  // Opcode as it stands once the current bit is in
  assign opcode_full = {opcode[6:0], pins.serial_in};

  // Serial clock history; mode 0 idle level avoids a false edge after reset
  always_comb begin
    next_sclk_prev = pins.sclk;
  end

  // History register, same reset domain as the interpreter
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= next_sclk_prev;
    end
  end

  // Interpreter next state
  always_comb begin
    next_state = state;
    next_opcode = opcode;
    next_addr = addr;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_shift_len = shift_len;
    next_shift_pos = shift_pos;
    next_payload = payload;
    next_out_bit = out_bit;
    next_out_en = out_en;
    next_sleeping = sleeping;
    next_wake_cnt = (wake_cnt != 8'h00) ? wake_cnt - 8'h01 : wake_cnt;
    case (state)
      FWID_IDLE: begin
        // Idle: output off, address cleared for the next frame
        next_out_en = 1'b0;
        next_addr = 24'h000000;
        // New selects wait out the wake delay
        if (sel_active && wake_cnt == 8'h00) begin
          next_state = FWID_OPCODE;
          next_bit_cnt = 6'h00;
          next_opcode = 8'h00;
        end
      end
      FWID_OPCODE: begin
        // Opcode: eight rising edges, decoded on the last one
        if (!sel_active) begin
          next_state = FWID_IDLE;
          // Sleep opcode acts on select rise; refused during a write cycle
          if (bit_cnt == OPCODE_BITS && opcode == OP_DEEP_SLEEP && !sleeping
              && !write_in_progress) begin
            next_sleeping = 1'b1;
          end
        end else if (sclk_rise && bit_cnt < OPCODE_BITS) begin
          next_opcode = opcode_full;
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == OPCODE_BITS - 6'h01) begin
            if (write_in_progress && (opcode_full == OP_WAKE_AND_CODE ||
                                      opcode_full == OP_THREE_BYTE_IDENT)) begin
              next_state = FWID_IGNORE;
            end else if (sleeping && opcode_full != OP_WAKE_AND_CODE) begin
              next_state = FWID_IGNORE;
            end else if (opcode_full == OP_THREE_BYTE_IDENT) begin
              next_payload = {MAKER_CODE_DEFAULT, MEM_TYPE_DEFAULT,
                              CAPACITY_DEFAULT};
              next_shift_len = SHIFT_LEN_IDENT;
              next_shift_pos = 5'd0;
              next_state = FWID_SHIFT;
            end else if (opcode_full == OP_DEEP_SLEEP) begin
              // Sleep opcode waits here; it only acts when select rises
              next_state = FWID_OPCODE;
            end else if (opcode_full == OP_MAKER_DEVICE ||
                         opcode_full == OP_WAKE_AND_CODE) begin
              next_state = FWID_ADDR;
            end else begin
              next_state = FWID_IGNORE;
            end
          end
        end
      end
      FWID_ADDR: begin
        // Address or dummy bytes; a bare wake opcode ends here
        if (!sel_active) begin
          next_state = FWID_IDLE;
          // Wake only when select rises straight after the opcode
          if (bit_cnt == OPCODE_BITS && opcode == OP_WAKE_AND_CODE && sleeping) begin
            next_sleeping = 1'b0;
            next_wake_cnt = WAKE_COUNT;
          end
        end else if (sclk_rise) begin
          next_addr = {addr[22:0], pins.serial_in};
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == ADDR_END_BITS - 6'h01) begin
            next_state = FWID_SHIFT;
            next_shift_pos = 5'd0;
            if (opcode == OP_WAKE_AND_CODE) begin
              next_payload = {DEVICE_CODE_DEFAULT, 16'h0000};
              next_shift_len = SHIFT_LEN_CODE;
            end else if ({addr[22:0], pins.serial_in} == SWAP_ADDR) begin
              next_payload = {DEVICE_CODE_DEFAULT, MAKER_CODE_DEFAULT, 8'h00};
              next_shift_len = SHIFT_LEN_PAIR;
            end else begin
              next_payload = {MAKER_CODE_DEFAULT, DEVICE_CODE_DEFAULT, 8'h00};
              next_shift_len = SHIFT_LEN_PAIR;
            end
          end
        end
      end
      FWID_SHIFT: begin
        // Shift out: one bit per falling edge, pattern wraps until deselect
        if (!sel_active) begin
          next_state = FWID_IDLE;
          next_out_en = 1'b0;
          // A code read while asleep also wakes, after the same WAKE_COUNT delay
          if (opcode == OP_WAKE_AND_CODE && sleeping) begin
            next_sleeping = 1'b0;
            next_wake_cnt = WAKE_COUNT;
          end
        end else if (sclk_fall) begin
          // Falling edge: present next bit MSB first, wrap to repeat
          next_out_en = 1'b1;
          next_out_bit = (shift_pos == 5'd0) ? payload[23] : shreg[23];
          next_shreg = (shift_pos == 5'd0) ? {payload[22:0], 1'b0}
                                           : {shreg[22:0], 1'b0};
          next_shift_pos = (shift_pos == shift_len) ? 5'd0 : shift_pos + 5'd1;
        end
      end
      FWID_IGNORE: begin
        // Ignored commands touch nothing until deselect
        if (!sel_active) begin
          next_state = FWID_IDLE;
        end
      end
      default: next_state = FWID_IDLE;
    endcase
    // Sleep request only from idle, so no frame is ever cut short
    if (sleep_request && !write_in_progress && state == FWID_IDLE) begin
      next_sleeping = 1'b1;
    end
  end

  // Interpreter registers
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      state <= FWID_IDLE;
      opcode <= 8'h00;
      addr <= 24'h000000;
      bit_cnt <= 6'h00;
      shreg <= 24'h000000;
      shift_len <= 5'd0;
      shift_pos <= 5'd0;
      payload <= 24'h000000;
      out_bit <= 1'b0;
      out_en <= 1'b0;
      sleeping <= 1'b0;
      wake_cnt <= 8'h00;
    end else begin
      state <= next_state;
      opcode <= next_opcode;
      addr <= next_addr;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      shift_len <= next_shift_len;
      shift_pos <= next_shift_pos;
      payload <= next_payload;
      out_bit <= next_out_bit;
      out_en <= next_out_en;
      sleeping <= next_sleeping;
      wake_cnt <= next_wake_cnt;
    end
  end

  // Outputs; array byte is a constant since no array lives here, status bit 0 follows write_in_progress
  assign serial_out_pin = out_bit;
  assign serial_out_oe = out_en;
  assign deep_sleep = sleeping;
  assign standby_ready = (state == FWID_IDLE) && (wake_cnt == 8'h00);
  assign status_byte = {STATUS_SHIPPED[7:1], write_in_progress};
  assign array_read_byte = ERASED_BYTE;

endmodule : fwid_top

// File: fwid_top_sva.sv
/* Checker for the wake and ident command block.
   Sees only the top module ports; bound at the foot. */
`timescale 1ns/10ps
module fwid_top_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link pins
  input wire logic select_low_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  // Device state
  input wire logic write_in_progress,
  input wire logic sleep_request,
  input wire logic deep_sleep,
  input wire logic standby_ready,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] array_read_byte
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Deselect, then a bounded return to standby
  sequence sel_rise_s;
    $rose(select_low_pin);
  endsequence
  // Ten core cycles is the whole wake bound, sync latency included
  sequence back_s;
    ##[1:10] (standby_ready || deep_sleep);
  endsequence
  a_oe_off_sel: assert property (sel_rise_s |-> ##[1:6] !serial_out_oe)
    else $error("output enable held after deselect");
  a_out_on_fall: assert property ($changed(serial_out_pin) |-> !serial_clock_pin)
    else $error("output bit moved while serial clock high");
  a_oe_when_sel: assert property ($rose(serial_out_oe) |-> !select_low_pin)
    else $error("output enabled while deselected");
  a_status_clear: assert property (status_byte[7:1] == 7'h00)
    else $error("status upper bits not clear");
  a_array_erased: assert property (array_read_byte == 8'hff)
    else $error("array byte not erased value");
  a_wake_bound: assert property (sel_rise_s |-> back_s)
    else $error("standby not reached in time");
  a_busy_silent: assert property (write_in_progress |-> !$rose(serial_out_oe))
    else $error("output started during write cycle");
  a_wake_desel: assert property ($fell(deep_sleep) |-> select_low_pin)
    else $error("left sleep while selected");
endmodule : fwid_top_sva

bind fwid_top fwid_top_sva u_sva (.core_clk(core_clk), .rst_n(rst_n),
  .select_low_pin(select_low_pin), .serial_clock_pin(serial_clock_pin),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe), .write_in_progress(write_in_progress),
  .sleep_request(sleep_request), .deep_sleep(deep_sleep),
  .standby_ready(standby_ready), .status_byte(status_byte),
  .array_read_byte(array_read_byte));

// File: fwid_host.sv
/* Host model of the serial link master, mode 0, 160 ns clock.
   Assumes a 100 MHz core_clk as timebase; pins move just after its edges. */
`timescale 1ns/10ps
module fwid_host (
  // Timebase
  input wire logic core_clk,
  // Device side
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  // Host-driven pins
  output logic select_low_pin,
  output logic serial_clock_pin,
  output logic serial_in_pin
);
  // Idle link: deselected, clock low
  initial begin
    select_low_pin = 1'b1;
    serial_clock_pin = 1'b0;
    serial_in_pin = 1'b0;
  end
  // One frame: ntx bits MSB first, then nrx bits read on rising clock
  task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx,
                      output logic [47:0] rx, output logic oe_seen);
    rx = '0;
    oe_seen = 1'b0;
    @(posedge core_clk);
    select_low_pin <= 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      if (i < ntx) serial_in_pin <= tx[ntx - 1 - i];
      else serial_in_pin <= ~serial_in_pin;
      repeat (8) @(posedge core_clk);
      // Undriven line reads as the inverse of the last bit
      if (i >= ntx) rx = {rx[46:0], serial_out_oe ? serial_out_pin : ~rx[0]};
      oe_seen = oe_seen | serial_out_oe;
      serial_clock_pin <= 1'b1;
      repeat (8) @(posedge core_clk);
      serial_clock_pin <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
    select_low_pin <= 1'b1;
    serial_in_pin <= ~serial_in_pin;
    // Deselect gap covers either wake delay
    repeat (24) @(posedge core_clk);
  endtask : xfer
endmodule : fwid_host

// File: fwid_top_test.sv
/* Self-checking bench for the wake and ident block.
   Assumes the host model drives the link; checker bound separately. */
`timescale 1ns/10ps
module fwid_top_test;
  import fwid_pkg::*;
  localparam logic [7:0] MK = MAKER_CODE_DEFAULT;
  localparam logic [7:0] DV = DEVICE_CODE_DEFAULT;
  logic core_clk, rst_n, write_in_progress, sleep_request;
  logic select_low_pin, serial_clock_pin, serial_in_pin;
  logic serial_out_pin, serial_out_oe, deep_sleep, standby_ready;
  logic [7:0] status_byte, array_read_byte;
  logic [47:0] rx;
  logic oe_seen;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  fwid_top uut (.core_clk(core_clk), .rst_n(rst_n), .select_low_pin(select_low_pin),
    .serial_clock_pin(serial_clock_pin), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .write_in_progress(write_in_progress), .sleep_request(sleep_request),
    .deep_sleep(deep_sleep), .standby_ready(standby_ready),
    .status_byte(status_byte), .array_read_byte(array_read_byte));
  fwid_host host (.core_clk(core_clk), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .select_low_pin(select_low_pin),
    .serial_clock_pin(serial_clock_pin), .serial_in_pin(serial_in_pin));
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  // Hang guard, well above the expected run
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      finish_test();
    end
  end
  // Ident read long enough to wrap
  task automatic t_ident();
    host.xfer({24'h0, OP_THREE_BYTE_IDENT}, 8, 48, rx, oe_seen);
    chk(rx, {2{MK, MEM_TYPE_DEFAULT, CAPACITY_DEFAULT}});
    $display("ident test done");
  endtask : t_ident
  // Both address orders
  task automatic t_maker();
    host.xfer({OP_MAKER_DEVICE, 24'h000000}, 32, 32, rx, oe_seen);
    chk(rx, {16'h0, {2{MK, DV}}});
    host.xfer({OP_MAKER_DEVICE, SWAP_ADDR}, 32, 32, rx, oe_seen);
    chk(rx, {16'h0, {2{DV, MK}}});
    $display("maker test done");
  endtask : t_maker
  // Device code with three dummies, repeated
  task automatic t_code();
    host.xfer({OP_WAKE_AND_CODE, 24'h0}, 32, 24, rx, oe_seen);
    chk(rx, {24'h0, {3{DV}}});
    $display("code test done");
  endtask : t_code
  // Ident and code reads refused during a write cycle
  task automatic t_busy();
    @(posedge core_clk);
    write_in_progress <= 1'b1;
    host.xfer({24'h0, OP_THREE_BYTE_IDENT}, 8, 8, rx, oe_seen);
    chk(oe_seen, 1'b0);
    host.xfer({OP_WAKE_AND_CODE, 24'h0}, 32, 8, rx, oe_seen);
    #1;
    chk({oe_seen, status_byte}, {1'b0, 8'h01});
    @(posedge core_clk);
    write_in_progress <= 1'b0;
    $display("busy test done");
  endtask : t_busy
  // Sleep, refused command, both wake forms
  task automatic t_sleep();
    host.xfer({24'h0, OP_DEEP_SLEEP}, 8, 0, rx, oe_seen);
    host.xfer({OP_MAKER_DEVICE, 24'h0}, 32, 16, rx, oe_seen);
    #1;
    chk({deep_sleep, oe_seen}, 2'b10);
    host.xfer({24'h0, OP_WAKE_AND_CODE}, 8, 0, rx, oe_seen);
    #1;
    chk({deep_sleep, standby_ready}, 2'b01);
    @(posedge core_clk);
    sleep_request <= 1'b1;
    repeat (4) @(posedge core_clk);
    sleep_request <= 1'b0;
    host.xfer({OP_WAKE_AND_CODE, 24'h0}, 32, 8, rx, oe_seen);
    #1;
    chk({deep_sleep, standby_ready, rx[7:0]}, {2'b01, DV});
    $display("sleep test done");
  endtask : t_sleep
  // Partial opcode, then ident cut short
  task automatic t_abort();
    host.xfer(32'h9, 4, 0, rx, oe_seen);
    host.xfer({24'h0, OP_THREE_BYTE_IDENT}, 8, 12, rx, oe_seen);
    chk(rx, {36'h0, MK, MEM_TYPE_DEFAULT[7:4]});
    t_ident();
    $display("abort test done");
  endtask : t_abort
  // Reset, shipped state, then the scenarios
  initial begin
    rst_n = 1'b0;
    write_in_progress = 1'b0;
    sleep_request = 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk({status_byte, array_read_byte}, {STATUS_SHIPPED, ERASED_BYTE});
    t_ident();
    t_maker();
    t_code();
    t_busy();
    t_sleep();
    t_abort();
    finish_test();
  end
endmodule : fwid_top_test
